// ==== logic/plr_pkg.sv ====
// package: offsets, field positions, reset values and timing for the power loss restart block
package plr_pkg;
  // ========================================================
  // clocking
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 100;                          // one timing tick is 0.1 ms
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_DSEC = 1000;                  // 0.1 s in ticks
  localparam int TICKS_PER_CSEC = 100;                   // 0.01 s in ticks
  localparam int LOSS_MS = 15;
  localparam logic [15:0] LOSS_TICKS = 16'(LOSS_MS * 10);
  // ========================================================
  // register offsets (byte addresses)
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_TIMES = 6'h04;
  localparam logic [5:0] OFF_LEVEL = 6'h08;
  localparam logic [5:0] OFF_STATUS = 6'h0C;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h10;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h14;
  localparam logic [5:0] OFF_VOLT = 6'h18;
  // ========================================================
  // field positions and reset values
  localparam int CTRL_REV_BIT = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_RIDE_LSB = 8;                      // 8 bits, 0.1 s units
  localparam int TIMES_BLK_LSB = 0;                      // 6 bits, 0.1 s units
  localparam int TIMES_REC_LSB = 8;                      // 6 bits, 0.1 s units
  localparam int TIMES_SS_LSB = 16;                      // 8 bits, 0.01 s units
  localparam logic [7:0] RIDE_RST = 8'h01;               // 0.1 s
  localparam logic [5:0] BLK_RST = 6'h02;                // 0.2 s
  localparam logic [5:0] BLK_MAX = 6'h32;                // 5.0 s
  localparam logic [5:0] REC_RST = 6'h03;                // 0.3 s
  localparam logic [7:0] SS_RST = 8'h0A;                 // 0.1 s
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [9:0] LEVEL_RST = 10'h0BE;            // 190 V
  localparam logic [9:0] LEVEL_MIN = 10'h096;            // 150 V
  localparam int IRQ_W = 3;                              // fault, loss, restart
  // ========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RUN = 6'b000010,
    ST_LOSS = 6'b000100,
    ST_BLOCK = 6'b001000,
    ST_SEARCH = 6'b010000,
    ST_RAMP = 6'b100000
  } seq_state_t;
endpackage

// ==== logic/tick_div.sv ====
// tick divider: one-cycle enable pulse every TICK_CYC clocks
`timescale 1ns/1ns
`default_nettype none
module tick_div
  import plr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // tick out
  output logic tick
);
  logic [15:0] cnt_reg;
  // ========================================================
  // free running divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign tick = (cnt_reg == 16'(TICK_CYC - 1));
endmodule // tick_div
`default_nettype wire

// ==== logic/axil_regs.sv ====
// axi4-lite slave with control registers and sticky interrupt status
`timescale 1ns/1ns
`default_nettype none
module axil_regs
  import plr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // settings out
  output logic [31:0] ctrl_reg,
  output logic [31:0] times_reg,
  output logic [9:0] level_reg,
  // state in
  input wire logic [31:0] status_in,
  input wire logic [9:0] volt_in,
  input wire logic [IRQ_W-1:0] irq_events,
  output logic irq
);
  logic aw_reg, w_reg;
  logic [5:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [IRQ_W-1:0] ist_reg, imask_reg;
  logic do_wr, do_rd, wr_ok, rd_ok;
  logic [31:0] rd_mux, lvl_merged;
  // byte-lane merge, used for the ctrl, times and level writes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    end
    return old;
  endfunction
  // ========================================================
  // handshake: address and data taken in either order
  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_reg && !s_axi_bvalid;
  assign do_wr = aw_reg && w_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign wr_ok = (awaddr_reg <= OFF_IRQ_MASK) && (awaddr_reg != OFF_STATUS);
  assign rd_ok = (s_axi_araddr <= OFF_VOLT);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[5:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ========================================================
  // register writes; level never below its floor
  assign lvl_merged = merge({22'h0, level_reg}, wdata_reg, wstrb_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= {16'h0000, RIDE_RST, 2'h0, SEL_RST, 4'h0};
      times_reg <= {8'h00, SS_RST, 2'h0, REC_RST, 2'h0, BLK_RST};
      level_reg <= LEVEL_RST;
      imask_reg <= '0;
    end else if (do_wr) begin
      unique case (awaddr_reg)
        OFF_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) &
            32'h0000_FF31;
        OFF_TIMES: times_reg <= merge(times_reg, wdata_reg, wstrb_reg) &
            32'h00FF_3F3F;
        OFF_LEVEL: level_reg <= (lvl_merged < {22'h0, LEVEL_MIN}) ?
            LEVEL_MIN : (lvl_merged > 32'h3FF) ? 10'h3FF : lvl_merged[9:0];
        OFF_IRQ_MASK: imask_reg <= wdata_reg[IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  // ========================================================
  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_reg <= '0;
    end else if (do_wr && awaddr_reg == OFF_IRQ_STAT && wstrb_reg[0]) begin
      ist_reg <= (ist_reg & ~wdata_reg[IRQ_W-1:0]) | irq_events;
    end else begin
      ist_reg <= ist_reg | irq_events;
    end
  end
  assign irq = |(ist_reg & imask_reg);
  // ========================================================
  // read path, data from a register
  assign rd_mux = (s_axi_araddr[5:2] == 4'h0) ? ctrl_reg :
      (s_axi_araddr[5:2] == 4'h1) ? times_reg :
      (s_axi_araddr[5:2] == 4'h2) ? {22'h0, level_reg} :
      (s_axi_araddr[5:2] == 4'h3) ? status_in :
      (s_axi_araddr[5:2] == 4'h4) ? {29'h0, ist_reg} :
      (s_axi_araddr[5:2] == 4'h5) ? {29'h0, imask_reg} :
      (s_axi_araddr[5:2] == 4'h6) ? {22'h0, volt_in} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // axil_regs
`default_nettype wire

// ==== logic/power_loss_restart_control.sv ====
// power loss restart sequencer with reverse prohibit, top module
// How it works
// - reverse command ignored when prohibit set; held with forward it still blocks the run
// - sel 1 restarts if power returns in time
// - sel 1 faults once loss exceeds ride-through
// - sel 2 always restarts, never faults
// - ride-through 0 to 25.5 s, default 0.1
// - output blocked at least min block time
// - voltage ramps zero to max over recovery
// - undervoltage when bus below settable level
// - error outputs held low during recovery
// - sel 0 faults on loss over 15 ms
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module power_loss_restart_control
  import plr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // run terminals and bus voltage
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic [9:0] dc_bus_volt,
  // drive outputs
  output logic out_enable,
  output logic out_reverse,
  output logic [7:0] volt_scale,
  output logic main_undervolt_fault,
  output logic error_out,
  output logic irq
);
  logic [31:0] ctrl_reg, times_reg, status_w;
  logic [9:0] level_reg;
  logic tick;
  logic reverse_prohibit_sel;
  logic [1:0] loss_handling_sel;
  logic [7:0] ride_through_time;
  logic [5:0] min_block_time, voltage_recovery_time;
  logic [7:0] search_time;
  logic undervolt_detect, run_req, rev_req;
  seq_state_t state_reg, state_next;
  logic [17:0] loss_cnt_reg, ride_lim;
  logic [15:0] phase_cnt_reg, blk_lim, ss_lim, rec_lim;
  logic fault_reg, dir_reg;
  logic ride_over, sel0_over, loss_timeout, phase_done;
  logic [7:0] volt_reg;
  logic [IRQ_W-1:0] irq_events;

  // tenths of a second to ticks, used for ride-through, block and recovery
  // 18 bits so the full 25.5 s ride-through fits in ticks
  function automatic logic [17:0] dsec_ticks(input logic [7:0] d);
    return 18'(d * TICKS_PER_DSEC);
  endfunction
  // ========================================================
  // register slave and tick divider
  axil_regs axil_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl_reg(ctrl_reg), .times_reg(times_reg), .level_reg(level_reg),
    .status_in(status_w), .volt_in(dc_bus_volt),
    .irq_events(irq_events), .irq(irq)
  );
  tick_div tick_div_inst (
    .aclk(aclk), .aresetn(aresetn), .tick(tick)
  );
  // ========================================================
  // settings fields
  assign reverse_prohibit_sel = ctrl_reg[CTRL_REV_BIT];
  assign loss_handling_sel = ctrl_reg[CTRL_SEL_LSB +: 2];
  assign ride_through_time = ctrl_reg[CTRL_RIDE_LSB +: 8];
  // block time clamped to its 5.0 s ceiling
  assign min_block_time = (times_reg[TIMES_BLK_LSB +: 6] > BLK_MAX) ?
      BLK_MAX : times_reg[TIMES_BLK_LSB +: 6];
  assign voltage_recovery_time = (times_reg[TIMES_REC_LSB +: 6] > BLK_MAX) ?
      BLK_MAX : times_reg[TIMES_REC_LSB +: 6];
  assign search_time = times_reg[TIMES_SS_LSB +: 8];
  // ========================================================
  // command and loss decode
  assign undervolt_detect = (dc_bus_volt < level_reg);
  // prohibited reverse gives no run, and still blocks a forward held with it
  assign rev_req = run_rev && !run_fwd && !reverse_prohibit_sel;
  assign run_req = (run_fwd && !run_rev) || rev_req;
  assign ride_lim = dsec_ticks(ride_through_time);
  // block and recovery stop at 5.0 s, so 16 bits hold them
  assign blk_lim = 16'(dsec_ticks({2'h0, min_block_time}));
  assign rec_lim = 16'(dsec_ticks({2'h0, voltage_recovery_time}));
  assign ss_lim = 16'(search_time * TICKS_PER_CSEC);
  assign ride_over = (loss_cnt_reg > ride_lim);
  assign sel0_over = (loss_cnt_reg > {2'h0, LOSS_TICKS});
  // sel 2 has no timeout at all; sel 3 treated as sel 0
  assign loss_timeout = (loss_handling_sel == 2'h1) ? ride_over :
      (loss_handling_sel == 2'h2) ? 1'b0 : sel0_over;
  assign phase_done = (state_reg == ST_BLOCK) ? (phase_cnt_reg >= blk_lim) :
      (state_reg == ST_SEARCH) ? (phase_cnt_reg >= ss_lim) :
      (phase_cnt_reg >= rec_lim);
  // ========================================================
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (run_req && !undervolt_detect && !fault_reg) begin
        state_next = ST_RAMP;
      end
      ST_RUN: if (undervolt_detect) begin
        state_next = ST_LOSS;
      end else if (!run_req) begin
        state_next = ST_IDLE;
      end
      // a return within the limit restarts through block time
      ST_LOSS: if (loss_timeout) begin
        state_next = ST_IDLE;
      end else if (!undervolt_detect) begin
        state_next = ST_BLOCK;
      end
      ST_BLOCK: if (undervolt_detect) begin
        state_next = ST_LOSS;
      end else if (phase_done) begin
        state_next = ST_SEARCH;
      end
      ST_SEARCH: if (undervolt_detect) begin
        state_next = ST_LOSS;
      end else if (phase_done) begin
        state_next = ST_RAMP;
      end
      ST_RAMP: if (undervolt_detect) begin
        state_next = ST_LOSS;
      end else if (!run_req) begin
        state_next = ST_IDLE;
      end else if (phase_done) begin
        state_next = ST_RUN;
      end
    endcase
  end
  // ========================================================
  // state, direction and fault latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      fault_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_LOSS && loss_timeout) begin
        fault_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && !run_req) begin
        fault_reg <= 1'b0; // reset by dropping the run command
      end
      if (state_reg == ST_IDLE && state_next == ST_RAMP) begin
        dir_reg <= rev_req;
      end
    end
  end
  // ========================================================
  // ride-through timer counts only while lost, cleared on return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_cnt_reg <= 18'h00000;
    end else if (state_reg != ST_LOSS || !undervolt_detect) begin
      loss_cnt_reg <= 18'h00000;
    end else if (tick && loss_cnt_reg != 18'h3FFFF) begin
      loss_cnt_reg <= loss_cnt_reg + 18'h00001;
    end
  end
  // ========================================================
  // phase timer for block, search and ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_cnt_reg <= 16'h0000;
    end else if (state_next != state_reg) begin
      phase_cnt_reg <= 16'h0000;
    end else if (tick && !phase_done) begin
      phase_cnt_reg <= phase_cnt_reg + 16'h0001;
    end
  end
  // ========================================================
  // voltage ramp: linear from 0 to full scale over the recovery time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_reg <= 8'h00;
    end else if (state_reg == ST_RUN) begin
      volt_reg <= 8'hFF;
    end else if (state_reg != ST_RAMP || rec_lim == 16'h0000) begin
      volt_reg <= (state_reg == ST_RAMP) ? 8'hFF : 8'h00;
    end else begin
      volt_reg <= 8'(({8'h00, phase_cnt_reg} * 24'h0000FF) /
          {8'h00, rec_lim});
    end
  end
  // ========================================================
  // outputs; block, loss and search keep the bridge off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_enable <= 1'b0;
      out_reverse <= 1'b0;
      volt_scale <= 8'h00;
      main_undervolt_fault <= 1'b0;
      error_out <= 1'b0;
    end else begin
      out_enable <= (state_reg == ST_RUN) || (state_reg == ST_RAMP);
      out_reverse <= dir_reg;
      volt_scale <= volt_reg;
      main_undervolt_fault <= fault_reg;
      // recovery states mask the error output
      error_out <= fault_reg && (state_reg == ST_IDLE);
    end
  end
  assign irq_events = {
    state_reg == ST_SEARCH && state_next == ST_RAMP,
    state_reg != ST_LOSS && state_next == ST_LOSS,
    state_reg == ST_LOSS && loss_timeout
  };
  assign status_w = {20'h0, fault_reg, dir_reg, out_enable,
      undervolt_detect, 2'h0, state_reg};
endmodule // power_loss_restart_control
`default_nettype wire

// ==== test/plr_props.sv ====
// checker: bus handshake and restart sequencing properties
`timescale 1ns/1ns
`default_nettype none
module plr_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic out_enable,
  input wire logic out_reverse,
  input wire logic main_undervolt_fault,
  input wire logic error_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ========================================================
  // bus handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  rdata_hold_a: assert property
    (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  aw_block_a: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // ========================================================
  // sequencer outputs
  err_idle_a: assert property (error_out |-> !out_enable)
    else $error("error shown while output runs");
  fault_latch_a: assert property
    (main_undervolt_fault && run_fwd && !run_rev |=> main_undervolt_fault)
    else $error("fault lost while run held");
  dir_hold_a: assert property
    (out_enable ##1 out_enable |-> $stable(out_reverse))
    else $error("direction changed while running");
endmodule // plr_props
bind power_loss_restart_control plr_props plr_props_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .run_fwd, .run_rev, .out_enable,
  .out_reverse, .main_undervolt_fault, .error_out);
`default_nettype wire

// ==== test/motor_side.sv ====
// partner model: run terminals and main supply of the drive
`timescale 1ns/1ns
`default_nettype none
module motor_side (
  // clock
  input wire logic aclk,
  // bench requests
  input wire logic want_fwd,
  input wire logic want_rev,
  input wire logic [9:0] want_volt,
  // terminals and bus
  output logic run_fwd,
  output logic run_rev,
  output logic [9:0] dc_bus_volt
);
  // run stays held across a supply dip so the drive can resume
  always_ff @(posedge aclk) begin
    run_fwd <= want_fwd;
    run_rev <= want_rev;
    dc_bus_volt <= want_volt;
  end
endmodule // motor_side
`default_nettype wire

// ==== test/power_loss_restart_control_test.sv ====
// testbench for the power loss restart block
`timescale 1ns/1ns
`default_nettype none
module power_loss_restart_control_test;
  import plr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [5:0] araddr = 6'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic want_fwd = 1'b0;
  logic want_rev = 1'b0;
  logic [9:0] want_volt = 10'h0FA;
  wire awready, wready, bvalid, arready, rvalid, run_fwd, run_rev;
  wire out_enable, out_reverse, fault, error_out, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [9:0] dc_bus_volt;
  wire [7:0] volt_scale;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] lfsr = 16'hC71B;
  logic [33:0] rd_q[$];
  power_loss_restart_control power_loss_restart_control_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .run_fwd(run_fwd), .run_rev(run_rev),
    .dc_bus_volt(dc_bus_volt), .out_enable(out_enable),
    .out_reverse(out_reverse), .volt_scale(volt_scale),
    .main_undervolt_fault(fault), .error_out(error_out), .irq(irq));
  motor_side motor_side_inst (.aclk(aclk), .want_fwd(want_fwd),
    .want_rev(want_rev), .want_volt(want_volt), .run_fwd(run_fwd),
    .run_rev(run_rev), .dc_bus_volt(dc_bus_volt));
  // ========================================================
  // clock, watchdog and shared tasks
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("unexpected timeout after %0d cycles", cycles);
      finish_test();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string name, input logic [33:0] e,
                     input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask
  // answers come back in issue order, so the oldest note matches
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
      chk("read word", rd_q.pop_front(), {rresp, rdata});
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic a_done;
    logic w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_done && w_done)) begin
      @(posedge aclk);
      if (!a_done && awready === 1'b1) begin
        a_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write response", {32'h0, r}, {32'h0, bresp});
  endtask
  // slow reads leave rready low until the answer shows
  task automatic rd(input logic [5:0] a, input logic [33:0] e,
                    input bit slow);
    rd_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    if (slow) begin
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
    end
    do @(posedge aclk); while (rvalid !== 1'b1 || rready !== 1'b1);
    rready <= 1'b0;
  endtask
  function automatic logic pick(input int k);
    return k ? fault : out_enable;
  endfunction
  task automatic wait_sig(input int k, input logic v, input string name);
    int n;
    n = 0;
    while (pick(k) !== v && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    chk(name, 34'(v), 34'(pick(k)));
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL, 34'h0_0000_0100, 1'b0);
    rd(OFF_TIMES, 34'h0_000A_0302, 1'b1);
    rd(OFF_LEVEL, 34'h0_0000_00BE, 1'b0);
    rd(6'h1C, 34'h2_0000_0000, 1'b0);
    wr(OFF_STATUS, 32'h0, 2'b10);
    wr(OFF_LEVEL, 32'h64, 2'b00);
    rd(OFF_LEVEL, 34'h0_0000_0096, 1'b0);
    wr(OFF_LEVEL, 32'hBE, 2'b00);
    wr(OFF_TIMES, 32'h0, 2'b00);
    wr(OFF_IRQ_MASK, 32'h7, 2'b00);
    // healthy random supply level, read back through the bus
    lfsr = lfsr_next(lfsr);
    want_volt <= 10'h0C8 + {2'b00, lfsr[7:0]};
    repeat (4) @(posedge aclk);
    rd(OFF_VOLT, {24'h0, want_volt}, 1'b0);
    // reverse refused while prohibited, then accepted
    wr(OFF_CTRL, 32'h111, 2'b00);
    want_rev <= 1'b1;
    repeat (200) @(posedge aclk);
    chk("out_enable", 34'h0, {33'h0, out_enable});
    wr(OFF_CTRL, 32'h110, 2'b00);
    wait_sig(0, 1'b1, "reverse start");
    chk("out_reverse", 34'h1, {33'h0, out_reverse});
    want_rev <= 1'b0;
    wait_sig(0, 1'b0, "stop");
    // short dip inside ride-through restarts without fault
    want_fwd <= 1'b1;
    wait_sig(0, 1'b1, "forward start");
    chk("out_reverse", 34'h0, {33'h0, out_reverse});
    wr(OFF_IRQ_STAT, 32'h7, 2'b00);
    want_volt <= 10'd100;
    wait_sig(0, 1'b0, "blocked in loss");
    rd(OFF_STATUS, 34'h0_0000_0104, 1'b0);
    chk("volt_scale", 34'h0, {26'h0, volt_scale});
    want_volt <= 10'd250;
    wait_sig(0, 1'b1, "restart");
    chk("fault", 34'h0, {33'h0, fault});
    chk("error_out", 34'h0, {33'h0, error_out});
    rd(OFF_IRQ_STAT, 34'h0_0000_0006, 1'b0);
    chk("volt_scale", 34'hFF, {26'h0, volt_scale});
    chk("irq", 34'h1, {33'h0, irq});
    wr(OFF_IRQ_STAT, 32'h7, 2'b00);
    chk("irq", 34'h0, {33'h0, irq});
    // selection 2 rides any dip and never faults
    wr(OFF_CTRL, 32'h020, 2'b00);
    want_volt <= 10'd100;
    repeat (12000) @(posedge aclk);
    chk("fault", 34'h0, {33'h0, fault});
    want_volt <= 10'd250;
    wait_sig(0, 1'b1, "restart");
    // zero ride-through: fault once the loss outlasts it
    wr(OFF_CTRL, 32'h010, 2'b00);
    wr(OFF_IRQ_STAT, 32'h7, 2'b00);
    want_volt <= 10'd100;
    wait_sig(1, 1'b1, "fault");
    repeat (3) @(posedge aclk);
    chk("error_out", 34'h1, {33'h0, error_out});
    rd(OFF_IRQ_STAT, 34'h0_0000_0003, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0, 2'b00);
    chk("irq", 34'h0, {33'h0, irq});
    wr(OFF_IRQ_MASK, 32'h7, 2'b00);
    chk("irq", 34'h1, {33'h0, irq});
    wr(OFF_IRQ_STAT, 32'h3, 2'b00);
    chk("irq", 34'h0, {33'h0, irq});
    want_volt <= 10'd250;
    want_fwd <= 1'b0;
    wait_sig(1, 1'b0, "fault release");
    finish_test();
  end
endmodule // power_loss_restart_control_test
`default_nettype wire
